// >>> inc/clkwd_map.vh
// Summary of operation
// R1: Lost input clock selects limp clock
// R2: Limp entry latches NMI and missing-clock flag
// R3: NMI select: immediate reset or counter overflow
// R4: Watchdog maximum drives reset low 512 clocks
// R5: Key 0x55 then 0xAA clears watchdog counter
// R6: Watchdog counter holds while limp clock runs
// R7: Standby keeps only watchdog on oscillator clock
// R8: Idle routes watchdog wake to interrupt expander
// R9: Halt watchdog expiry wakes by device reset
// R10: Mode field 00 idle, 01 standby, 1X halt
// R11: Per-mode gating of oscillator, CPU, system clocks
// R12: Idle exits on reset, watchdog, enabled interrupt
// R13: Standby and halt exit sources as listed
// R14: Wake sources held low long enough
// R15: Halt entered only with watchdog clock active
// R16: Standby wake pin qualified programmed oscillator clocks
// R17: Halt wake pin chosen by wake-pin select
// R18: Outputs hold values during low-power modes
// R19: Debug port stays alive while CPU clock stopped
// R20: Idle instruction enters mode sampled then
`ifndef CLKWD_MAP_VH
`define CLKWD_MAP_VH
`define WD_RST_CYCLES   10'h0200
`define WD_KEY_FIRST    8'h55
`define WD_KEY_SECOND   8'hAA
`define WD_CNT_MAX      8'hFF
`define WD_CNT_RESET    8'h00
`define NMI_CNT_RESET   16'h0000
`define NMI_PERIOD_DEF  16'hFFFF
`define LPM_IDLE        2'b00
`define LPM_STANDBY     2'b01
`define LPM_HALT_BIT    1
`define QUAL_RESET      6'h00
`define CLK_LOSS_LIMIT  8'h40
`define PINS_WIDTH      32
`endif

// >>> src/clock_fail_watchdog_lowpower.v
`timescale 1ns/1ns
`include "clkwd_map.vh"
module clock_fail_watchdog_lowpower #(
    parameter        WD_PRESCALE = 9,
    parameter [15:0] NMI_PERIOD  = `NMI_PERIOD_DEF
) (
    // Clock and reset
    input  wire        SYS_CLK,
    input  wire        RST_N,
    // Clock supervision
    input  wire        INPUT_CLK_TOGGLE,
    input  wire        NMI_RESET_SELECT,
    input  wire        NMI_CLEAR,
    output reg         LIMP_CLOCK_SEL,
    output reg         CLOCK_LOSS_SIGNAL,
    output reg         MISSING_CLOCK_FLAG,
    // CPU watchdog
    input  wire        WDOG_DISABLE,
    input  wire        WDOG_KEY_WR,
    input  wire [7:0]  WDOG_KEY_DATA,
    input  wire        WDOG_IRQ_MODE,
    input  wire        WDOG_CLOCK_ACTIVE,
    output reg  [7:0]  WDOG_COUNT,
    output reg         WDOG_RESET_OUT_N,
    output reg         WDOG_WAKE_IRQ_N,
    output reg         DEVICE_RESET_N,
    // Low-power control
    input  wire        IDLE_EXEC,
    input  wire [1:0]  LOWPOWER_MODE_FIELD,
    input  wire [5:0]  LOWPOWER_CTRL0_QUAL,
    input  wire [31:0] WAKE_PIN_SELECT,
    input  wire [31:0] GPIO_PORTA_IN,
    input  wire        EXT_RESET_PIN_N,
    input  wire        DEBUG_WAKE,
    input  wire        ENABLED_IRQ,
    output reg         INTERRUPT_EXPANDER_WD,
    output reg         OSC_CLOCK_EN,
    output reg         CPU_CLOCK_IN_EN,
    output reg         SYSTEM_CLOCK_OUT_EN,
    output reg         PLL_OSC_EN,
    output reg         PERIPH_EN,
    output reg         OUTPUT_HOLD,
    output reg         JTAG_CLOCK_EN,
    output reg  [1:0]  ACTIVE_MODE
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    wire        clk_tog_s;
    wire        xrs_n_s;
    wire        dbg_s;
    wire [31:0] gpio_s;

    sync2 #(.WIDTH(35), .INIT({1'b0, 1'b1, 1'b0, 32'hFFFF_FFFF})) u_sync (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .d     ({INPUT_CLK_TOGGLE, EXT_RESET_PIN_N, DEBUG_WAKE, GPIO_PORTA_IN}),
        .q     ({clk_tog_s, xrs_n_s, dbg_s, gpio_s})
    );

    // ------------------------------------------------------------
    // Missing clock detection and NMI watchdog
    // ------------------------------------------------------------
    reg        tog_d_reg;
    reg [7:0]  loss_cnt_reg;
    reg [15:0] nmi_cnt_reg;
    wire       clk_edge = clk_tog_s ^ tog_d_reg;
    wire       loss_now = (loss_cnt_reg == `CLK_LOSS_LIMIT);
    wire       nmi_fire = CLOCK_LOSS_SIGNAL &
                          (!NMI_RESET_SELECT | (nmi_cnt_reg == NMI_PERIOD)); // R3

    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tog_d_reg          <= 1'b0;
            loss_cnt_reg       <= 8'h00;
            nmi_cnt_reg        <= `NMI_CNT_RESET;
            LIMP_CLOCK_SEL     <= 1'b0;
            CLOCK_LOSS_SIGNAL  <= 1'b0;
            MISSING_CLOCK_FLAG <= 1'b0;
        end else begin
            tog_d_reg <= clk_tog_s;
            if (clk_edge)
                loss_cnt_reg <= 8'h00;
            else if (!loss_now)
                loss_cnt_reg <= loss_cnt_reg + 8'h01;
            // Limp stays selected until RST_N resets the block, not cleared by DEVICE_RESET_N; the input is not trusted again
            if (loss_now) begin
                LIMP_CLOCK_SEL     <= 1'b1; // R1
                MISSING_CLOCK_FLAG <= 1'b1; // R2
            end
            // Set wins over software clear
            if (loss_now)
                CLOCK_LOSS_SIGNAL <= 1'b1; // R2
            else if (NMI_CLEAR)
                CLOCK_LOSS_SIGNAL <= 1'b0;
            if (CLOCK_LOSS_SIGNAL && NMI_RESET_SELECT && nmi_cnt_reg != NMI_PERIOD)
                nmi_cnt_reg <= nmi_cnt_reg + 16'h0001; // R3
            else if (!CLOCK_LOSS_SIGNAL)
                nmi_cnt_reg <= `NMI_CNT_RESET;
        end
    end

    // ------------------------------------------------------------
    // CPU watchdog
    // ------------------------------------------------------------
    reg [8:0] pre_reg;
    reg       key_armed_reg;
    reg [9:0] rst_cnt_reg;
    wire      wd_tick = (pre_reg == WD_PRESCALE[8:0]);
    wire      key_done = WDOG_KEY_WR && key_armed_reg &&
                         (WDOG_KEY_DATA == `WD_KEY_SECOND);
    wire      wd_expire = wd_tick && !WDOG_DISABLE && !LIMP_CLOCK_SEL &&
                          (WDOG_COUNT == `WD_CNT_MAX);

    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_reg          <= 9'h000;
            key_armed_reg    <= 1'b0;
            rst_cnt_reg      <= 10'h000;
            WDOG_COUNT       <= `WD_CNT_RESET;
            WDOG_RESET_OUT_N <= 1'b1;
            WDOG_WAKE_IRQ_N  <= 1'b1;
        end else begin
            pre_reg <= wd_tick ? 9'h000 : pre_reg + 9'h001;
            if (WDOG_KEY_WR)
                key_armed_reg <= (WDOG_KEY_DATA == `WD_KEY_FIRST); // R5
            // Counter is parked while a pulse stands, so a fast prescale
            // cannot expire again and stretch the pulse
            if (key_done || WDOG_DISABLE || rst_cnt_reg != 10'h000)
                WDOG_COUNT <= `WD_CNT_RESET; // R5
            else if (wd_tick && !LIMP_CLOCK_SEL)
                WDOG_COUNT <= WDOG_COUNT + 8'h01; // R6
            // One pulse timer serves both the reset and the wake output
            if (wd_expire)
                rst_cnt_reg <= `WD_RST_CYCLES; // R4
            else if (rst_cnt_reg != 10'h000)
                rst_cnt_reg <= rst_cnt_reg - 10'h001;
            WDOG_RESET_OUT_N <= !(!WDOG_IRQ_MODE &&
                                  (wd_expire || rst_cnt_reg > 10'h001)); // R4
            // Active-low wake pulse of at least 513 clocks, long enough to be recognised
            if (wd_expire && WDOG_IRQ_MODE)
                WDOG_WAKE_IRQ_N <= 1'b0; // R7
            else if (rst_cnt_reg == 10'h000 && wd_tick)
                WDOG_WAKE_IRQ_N <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Low-power mode control
    // ------------------------------------------------------------
    localparam [3:0] ST_RUN     = 4'b0001;
    localparam [3:0] ST_IDLE    = 4'b0010;
    localparam [3:0] ST_STANDBY = 4'b0100;
    localparam [3:0] ST_HALT    = 4'b1000;

    // Core clocks run in normal operation and in idle only
    function core_clocks_on;
        input [3:0] st;
        begin
            core_clocks_on = (st == ST_RUN) || (st == ST_IDLE);
        end
    endfunction

    reg  [3:0] state_reg;
    reg  [3:0] state_next;
    reg  [5:0] qual_reg;
    wire [`PINS_WIDTH-1:0] pin_hit;
    genvar                 pin_idx;

    // A pin counts only when selected and seen low after synchronising
    generate
        for (pin_idx = 0; pin_idx < `PINS_WIDTH; pin_idx = pin_idx + 1) begin : g_pin
            assign pin_hit[pin_idx] = WAKE_PIN_SELECT[pin_idx] & ~gpio_s[pin_idx]; // R17
        end
    endgenerate

    wire       pin_low  = |pin_hit; // R17
    wire       pin_wake = pin_low && (qual_reg >= LOWPOWER_CTRL0_QUAL); // R16
    wire       wd_low   = !WDOG_WAKE_IRQ_N;
    wire       wd_rst   = !WDOG_RESET_OUT_N;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (IDLE_EXEC) begin // R20
                    if (LOWPOWER_MODE_FIELD[`LPM_HALT_BIT]) begin
                        if (WDOG_CLOCK_ACTIVE)
                            state_next = ST_HALT; // R15
                    end else if (LOWPOWER_MODE_FIELD == `LPM_STANDBY)
                        state_next = ST_STANDBY; // R10
                    else
                        state_next = ST_IDLE; // R10
                end
            end
            ST_IDLE: begin
                if (!xrs_n_s || wd_low || ENABLED_IRQ)
                    state_next = ST_RUN; // R12
            end
            ST_STANDBY: begin
                if (!xrs_n_s || wd_low || pin_wake || dbg_s)
                    state_next = ST_RUN; // R13
            end
            ST_HALT: begin
                if (!xrs_n_s || pin_wake || dbg_s || wd_rst || wd_low)
                    state_next = ST_RUN; // R13
            end
            default: state_next = ST_RUN;
        endcase
    end

    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg             <= ST_RUN;
            qual_reg              <= `QUAL_RESET;
            INTERRUPT_EXPANDER_WD <= 1'b0;
            DEVICE_RESET_N        <= 1'b1;
            OSC_CLOCK_EN          <= 1'b1;
            CPU_CLOCK_IN_EN       <= 1'b1;
            SYSTEM_CLOCK_OUT_EN   <= 1'b1;
            PLL_OSC_EN            <= 1'b1;
            PERIPH_EN             <= 1'b1;
            OUTPUT_HOLD           <= 1'b0;
            JTAG_CLOCK_EN         <= 1'b1;
            ACTIVE_MODE           <= `LPM_IDLE;
        end else begin
            state_reg <= state_next;
            if (pin_low && (state_reg == ST_STANDBY || state_reg == ST_HALT)) begin
                if (qual_reg != 6'h3F)
                    qual_reg <= qual_reg + 6'h01; // R16
            end else
                qual_reg <= `QUAL_RESET;
            INTERRUPT_EXPANDER_WD <= wd_low && (state_reg != ST_STANDBY); // R8
            DEVICE_RESET_N <= !(wd_rst || nmi_fire ||
                                (state_reg == ST_HALT && wd_low)); // R9
            OSC_CLOCK_EN        <= (state_next != ST_HALT); // R11
            PLL_OSC_EN          <= (state_next != ST_HALT); // R11
            CPU_CLOCK_IN_EN     <= core_clocks_on(state_next); // R11
            SYSTEM_CLOCK_OUT_EN <= core_clocks_on(state_next);
            PERIPH_EN           <= core_clocks_on(state_next); // R7
            OUTPUT_HOLD         <= (state_next != ST_RUN); // R18
            JTAG_CLOCK_EN       <= 1'b1; // R19
            if (IDLE_EXEC && state_reg == ST_RUN)
                ACTIVE_MODE <= LOWPOWER_MODE_FIELD; // R20
        end
    end
endmodule // clock_fail_watchdog_lowpower

// >>> src/sync2.v
`timescale 1ns/1ns
module sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Data
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= INIT;
            q        <= INIT;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // sync2

// >>> verification/clkwd_checker.sv
`timescale 1ns/1ns
module clkwd_checker (
    // Clock and reset
    input wire       SYS_CLK, RST_N,
    // Watchdog
    input wire       WDOG_KEY_WR, WDOG_RESET_OUT_N, DEVICE_RESET_N, WDOG_DISABLE,
    input wire [7:0] WDOG_KEY_DATA, WDOG_COUNT,
    // Clock supervision
    input wire       LIMP_CLOCK_SEL, CLOCK_LOSS_SIGNAL, MISSING_CLOCK_FLAG, NMI_RESET_SELECT,
    // Low power
    input wire       IDLE_EXEC, WDOG_CLOCK_ACTIVE, CPU_CLOCK_IN_EN, OSC_CLOCK_EN,
    input wire       SYSTEM_CLOCK_OUT_EN, PERIPH_EN, PLL_OSC_EN, OUTPUT_HOLD, JTAG_CLOCK_EN,
    input wire [1:0] LOWPOWER_MODE_FIELD, ACTIVE_MODE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    reg       armed_reg;
    reg [9:0] low_cnt_reg;
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            armed_reg   <= 1'b0;
            low_cnt_reg <= 10'h000;
        end else begin
            if (WDOG_KEY_WR)
                armed_reg <= (WDOG_KEY_DATA == 8'h55);
            low_cnt_reg <= WDOG_RESET_OUT_N ? 10'h000 : low_cnt_reg + 10'h001;
        end
    end
    sequence flags_up;
        CLOCK_LOSS_SIGNAL && MISSING_CLOCK_FLAG;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_key_clear: assert property (WDOG_KEY_WR && WDOG_KEY_DATA == 8'hAA && armed_reg
        |=> WDOG_COUNT == 8'h00) else $error("key sequence left counter set");
    chk_reset_width: assert property ($rose(WDOG_RESET_OUT_N)
        |-> low_cnt_reg == 10'h200) else $error("watchdog reset width wrong");
    chk_limp_flags: assert property ($rose(LIMP_CLOCK_SEL) |-> ##[0:2] flags_up)
        else $error("limp entry without loss flags");
    chk_limp_hold: assert property ($past(LIMP_CLOCK_SEL, 2) && !$past(WDOG_KEY_WR)
        && !$past(WDOG_DISABLE) |-> $stable(WDOG_COUNT)) else $error("counter moved in limp");
    chk_nmi_now: assert property ($rose(CLOCK_LOSS_SIGNAL) && !NMI_RESET_SELECT
        |-> ##[0:3] !DEVICE_RESET_N) else $error("no immediate reset");
    chk_nmi_late: assert property ($rose(CLOCK_LOSS_SIGNAL) && NMI_RESET_SELECT
        |-> DEVICE_RESET_N [*8]) else $error("counted reset came early");
    chk_halt_refuse: assert property (IDLE_EXEC && LOWPOWER_MODE_FIELD[1]
        && !WDOG_CLOCK_ACTIVE && CPU_CLOCK_IN_EN |=> CPU_CLOCK_IN_EN [*2])
        else $error("halt entered without watchdog clock");
    chk_idle_clocks: assert property (IDLE_EXEC && LOWPOWER_MODE_FIELD == 2'b00
        |=> CPU_CLOCK_IN_EN && SYSTEM_CLOCK_OUT_EN && OSC_CLOCK_EN) else $error("idle gated");
    chk_standby_gate: assert property (!CPU_CLOCK_IN_EN && ACTIVE_MODE == 2'b01
        |-> OSC_CLOCK_EN && !SYSTEM_CLOCK_OUT_EN && !PERIPH_EN && OUTPUT_HOLD)
        else $error("standby gating wrong");
    chk_halt_gate: assert property (!CPU_CLOCK_IN_EN && ACTIVE_MODE[1]
        |-> !PLL_OSC_EN && OUTPUT_HOLD && JTAG_CLOCK_EN) else $error("halt gating wrong");
endmodule // clkwd_checker

bind clock_fail_watchdog_lowpower clkwd_checker u_chk (.*);

// >>> verification/clock_fail_watchdog_lowpower_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
`define WAIT(c, n) begin for (int k = 0; k < n && !(c); k++) step(1); \
    if (!(c)) begin bad_count++; tally_and_finish; end end
module clock_fail_watchdog_lowpower_tb_top;
    reg sys_clk = 0, rst_n = 0, nmi_sel = 1, wd_dis = 1, key_wr = 0, wd_act = 1, idle = 0;
    reg dbg = 0, clk_ok = 1, nmi_clr = 0;
    reg [7:0] key = 8'h00;
    reg [1:0] mode = 2'b00;
    reg [31:0] sel = 32'h0000_0100, pull = 32'h0000_0000;
    wire tog, limp, loss, miss, wd_rst_n, wake_n, dev_rst_n, interrupt_expander, osc, cpu, sys, pll, per, hold, jtag;
    wire [31:0] pins;
    wire [7:0] cnt;
    wire [1:0] amode;
    int bad_count = 0, n_checks = 0;
    always #5 sys_clk = ~sys_clk;
    wake_far_side u_far (.SYS_CLK(sys_clk), .clk_ok(clk_ok), .pull_low(pull), .toggle(tog),
        .pins(pins));
    clock_fail_watchdog_lowpower #(.WD_PRESCALE(0), .NMI_PERIOD(16'h0010)) u_dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .INPUT_CLK_TOGGLE(tog), .NMI_RESET_SELECT(nmi_sel),
        .NMI_CLEAR(nmi_clr), .LIMP_CLOCK_SEL(limp), .CLOCK_LOSS_SIGNAL(loss),
        .MISSING_CLOCK_FLAG(miss), .WDOG_DISABLE(wd_dis), .WDOG_KEY_WR(key_wr),
        .WDOG_KEY_DATA(key), .WDOG_IRQ_MODE(mode == 2'b00), .WDOG_CLOCK_ACTIVE(wd_act),
        .WDOG_COUNT(cnt), .WDOG_RESET_OUT_N(wd_rst_n), .WDOG_WAKE_IRQ_N(wake_n),
        .DEVICE_RESET_N(dev_rst_n), .IDLE_EXEC(idle), .LOWPOWER_MODE_FIELD(mode),
        .LOWPOWER_CTRL0_QUAL(6'h04), .WAKE_PIN_SELECT(sel), .GPIO_PORTA_IN(pins),
        .EXT_RESET_PIN_N(1'b1), .DEBUG_WAKE(dbg), .ENABLED_IRQ(1'b0),
        .INTERRUPT_EXPANDER_WD(interrupt_expander), .OSC_CLOCK_EN(osc), .CPU_CLOCK_IN_EN(cpu),
        .SYSTEM_CLOCK_OUT_EN(sys), .PLL_OSC_EN(pll), .PERIPH_EN(per), .OUTPUT_HOLD(hold),
        .JTAG_CLOCK_EN(jtag), .ACTIVE_MODE(amode));
    task step(input int n); repeat (n) @(posedge sys_clk); #1; endtask
    task do_reset; rst_n = 0; step(4); rst_n = 1; step(3); endtask
    task key_write(input [7:0] v); key = v; key_wr = 1; step(1); key_wr = 0; step(1); endtask
    task enter(input [1:0] m); mode = m; idle = 1; step(1); idle = 0; step(2); endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task t_key;
        wd_dis = 0; step(20);
        key_write(8'h55); key = 8'hAA; key_wr = 1; step(1); key_wr = 0; step(1);
        `CHK(cnt < 8'h02, 1'b1)
        step(30); key_write(8'hAA);
        `CHK(cnt > 8'h10, 1'b1)
        wd_dis = 1; step(2);
    endtask
    task t_expire;
        int n;
        enter(2'b10); wd_dis = 0;
        `CHK(cpu, 1'b0)
        `CHK(amode, 2'b10)
        `WAIT(!wd_rst_n, 300)
        step(1);
        `CHK(dev_rst_n, 1'b0)
        for (n = 1; !wd_rst_n && n < 600; n++) step(1);
        `CHK(n, 512)
        `CHK(cpu, 1'b1)
        wd_dis = 1; step(2);
    endtask
    task t_standby;
        enter(2'b01);
        `CHK({cpu, osc, hold, per}, 4'b0110)
        `CHK(amode, 2'b01)
        pull = sel; step(1); pull = 0; step(10);
        `CHK(cpu, 1'b0)
        pull = 32'h0000_0001; step(20); pull = 0;
        `CHK(cpu, 1'b0)
        pull = sel; `WAIT(cpu, 20) pull = 0; step(2);
    endtask
    task t_halt_idle;
        wd_act = 0; enter(2'b10);
        `CHK(cpu, 1'b1)
        wd_act = 1; enter(2'b11);
        `CHK({pll, jtag, sys, hold}, 4'b0101)
        dbg = 1; `WAIT(cpu, 10) dbg = 0; step(2);
        enter(2'b00);
        `CHK({cpu, sys}, 2'b11)
        wd_dis = 0; `WAIT(interrupt_expander, 300)
        `CHK(wake_n, 1'b0)
        wd_dis = 1; step(2);
    endtask
    task t_loss;
        logic [7:0] c;
        `WAIT(wake_n, 600)
        wd_dis = 0; clk_ok = 0; `WAIT(limp, 100)
        `CHK({loss, miss}, 2'b11)
        c = cnt; step(5);
        `CHK(c > 8'h20, 1'b1)
        `CHK(cnt, c)
        `CHK(dev_rst_n, 1'b1)
        `WAIT(!dev_rst_n, 40)
        nmi_clr = 1; step(1); nmi_clr = 0; step(1);
        `CHK(loss, 1'b1)
        clk_ok = 1; step(10); nmi_clr = 1; step(1); nmi_clr = 0; step(1);
        `CHK({loss, limp, dev_rst_n}, 3'b011)
        wd_dis = 1; clk_ok = 1; nmi_sel = 0; do_reset; step(20);
        `CHK(limp, 1'b0)
        clk_ok = 0; `WAIT(limp, 100) `WAIT(!dev_rst_n, 4)
    endtask
    initial begin
        do_reset;
        t_key; t_expire; t_standby; t_halt_idle; t_loss;
        tally_and_finish;
    end
endmodule // clock_fail_watchdog_lowpower_tb_top

// >>> verification/wake_far_side.sv
`timescale 1ns/1ns
module wake_far_side (
    input  wire        SYS_CLK,
    input  wire        clk_ok,
    input  wire [31:0] pull_low,
    output reg         toggle,
    output wire [31:0] pins
);
    reg [1:0] div_reg = 2'b00;
    initial toggle = 1'b0;
    // Pull-ups hold every released pin high
    assign pins = ~pull_low;
    // Input clock sample edge every 4 cycles; stops dead on failure
    always @(posedge SYS_CLK) begin
        div_reg <= div_reg + 2'b01;
        if (clk_ok && div_reg == 2'b11)
            toggle <= ~toggle;
    end
endmodule // wake_far_side
